// >>> hw/ltmc_mode_ctrl.sv
// mode controller for a single-wire bus transceiver with a regulator:
// sequences power-on, ready, operation, power-down and transmitter-off.
// assumes analog comparators arrive as asynchronous flags and that
// the open-drain pins are resolved outside from the enables given here
`timescale 1ns/10ps

// Operation
// - leave reset mode once supply passes on-threshold
// - supply under off-threshold returns to reset mode
// - reset mode: all off, chip-select picks next
// - power-down: transmitter and regulator off
// - wake in power-down enters ready, regulator on
// - power-down only reached from operation path
// - ready: regulator and receiver on, transmitter off
// - ready to operation on regulator ok, chip-select
// - at power-on chip-select high goes straight on
// - chip-select falling edge in operation: power-down
// - low fault line in operation forces transmitter-off mode
// - fault line back high re-enables transmitter
// - internal fault keeps transmitter off regardless
// - regulator not stable keeps transmitter off
// - transmitter-off exits on chip-select or fault line
// - wake needs bus low for minimum time
// - thermal overload kills transmitter and regulator
// - enabled transmitter: low data drives bus low
// - receive output follows the bus level
// - transmit/bus mismatch pulls the fault line low
// - mismatch reported only after debounce from falling
module ltmc_mode_ctrl
  import ltmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // asynchronous pin levels and analog flags
  input wire ltmc_pins_t pinsAsync,
  // open-drain bus driver, enable low while driving
  output logic busLineOut,
  output logic busLineOeN,
  // open-drain fault / transmit enable line
  output logic faultTxEnableLineOut,
  output logic faultTxEnableLineOeN,
  // host receive data
  output logic rxData,
  // mode and power status
  output ltmc_state_t modeState,
  output ltmc_power_t powerCtrl,
  output logic txEnable,
  output logic contentionFault
);

  // every check below is on the core clock, quiet during reset
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ***********************************************************
  // decoding
  // ***********************************************************
  // power plan of each mode, used by the power, enable and pin output registers
  function automatic ltmc_power_t modePower(input ltmc_state_t m);
    ltmc_power_t p;
    p = POWER_RESET;
    case (m)
      MODE_POR:
        p = '{regEnable: 1'b0, rxEnable: 1'b0, txAllowed: 1'b0,
              digitalReset: 1'b1};
      MODE_READY:
        p = '{regEnable: 1'b1, rxEnable: 1'b1, txAllowed: 1'b0,
              digitalReset: 1'b0};
      MODE_OPER:
        p = '{regEnable: 1'b1, rxEnable: 1'b1, txAllowed: 1'b1,
              digitalReset: 1'b0};
      MODE_PDOWN:
        p = '{regEnable: 1'b0, rxEnable: 1'b1, txAllowed: 1'b0,
              digitalReset: 1'b0};
      MODE_TXOFF:
        p = '{regEnable: 1'b1, rxEnable: 1'b1, txAllowed: 1'b0,
              digitalReset: 1'b0};
      default:
        p = POWER_RESET;
    endcase
    return p;
  endfunction : modePower

  // ***********************************************************
  // input synchroniser
  // ***********************************************************
  ltmc_pins_t pinsMeta_q; // first stage, read only by the second
  ltmc_pins_t pins_q; // usable levels
  logic csPrev_q; // chip-select one cycle back, for edges
  logic txPrev_q; // transmit data one cycle back

  // two flops on every asynchronous level, then edge history
  // taken from the second stage only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinsMeta_q <= PINS_RESET;
      pins_q <= PINS_RESET;
      csPrev_q <= 1'b0;
      txPrev_q <= 1'b1;
    end
    else
    begin
      pinsMeta_q <= pinsAsync;
      pins_q <= pinsMeta_q;
      csPrev_q <= pins_q.chipSelectWakeIn;
      txPrev_q <= pins_q.txData;
    end
  end

  logic csFall; // chip-select falling edge
  logic txFall; // transmit data falling edge
  assign csFall = csPrev_q & ~pins_q.chipSelectWakeIn;
  assign txFall = txPrev_q & ~pins_q.txData;

  // ***********************************************************
  // wake filter
  // ***********************************************************
  logic [CNT_W-1:0] wakeCnt_q; // cycles the bus has stayed low
  logic busWake_q; // qualified bus activity

  // any high sample restarts the count, so glitches never wake
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wakeCnt_q <= CNT_ZERO;
      busWake_q <= 1'b0;
    end
    else if (modeState != MODE_PDOWN || !pins_q.busBelowWake)
    begin
      wakeCnt_q <= CNT_ZERO;
      busWake_q <= 1'b0;
    end
    else if (wakeCnt_q != WAKE_CYC)
    begin
      wakeCnt_q <= wakeCnt_q + CNT_ONE;
      busWake_q <= (wakeCnt_q + CNT_ONE) == WAKE_CYC;
    end
  end

  // ***********************************************************
  // contention detector
  // ***********************************************************
  logic [CNT_W-1:0] blankCnt_q; // debounce after transmit falls
  logic contention_q; // latched mismatch, cleared by tx high

  // bus propagation would give false mismatches right after a
  // falling edge, so the compare is blanked for the debounce time
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      blankCnt_q <= CNT_ZERO;
    end
    else if (txFall)
    begin
      blankCnt_q <= DEBOUNCE_CYC;
    end
    else if (blankCnt_q != CNT_ZERO)
    begin
      blankCnt_q <= blankCnt_q - CNT_ONE;
    end
  end

  // held until the host returns transmit high; releasing on the
  // disabled driver instead would oscillate the fault line
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      contention_q <= 1'b0;
    end
    else if (pins_q.txData)
    begin
      contention_q <= 1'b0;
    end
    else if (txEnable && blankCnt_q == CNT_ZERO && !txFall &&
             pins_q.busLine)
    begin
      contention_q <= 1'b1;
    end
  end

  // ***********************************************************
  // mode sequencer
  // ***********************************************************
  logic internalFault; // any internal cause that forbids the transmitter
  assign internalFault = contention_q | pins_q.thermalOverload |
                         ~pins_q.regOk;

  ltmc_state_t state_d;

  always_comb
  begin
    state_d = modeState;
    if (modeState != MODE_POR && pins_q.supplyBelowOff)
    begin
      state_d = MODE_POR;
    end
    else
    begin
      case (modeState)
        MODE_POR:
        begin
          // digital section held until the supply is good
          if (pins_q.supplyAboveOn)
          begin
            state_d = pins_q.chipSelectWakeIn ? MODE_OPER
                                              : MODE_READY;
          end
        end
        MODE_READY:
        begin
          if (pins_q.regOk && pins_q.chipSelectWakeIn)
          begin
            state_d = MODE_OPER;
          end
        end
        MODE_OPER:
        begin
          if (csFall)
          begin
            state_d = MODE_PDOWN;
          end
          else if (!pins_q.faultTxEnableLine)
          begin
            state_d = MODE_TXOFF;
          end
        end
        MODE_TXOFF:
        begin
          if (!pins_q.chipSelectWakeIn)
          begin
            state_d = MODE_PDOWN;
          end
          else if (pins_q.faultTxEnableLine)
          begin
            state_d = MODE_OPER;
          end
        end
        MODE_PDOWN:
        begin
          if (busWake_q || pins_q.chipSelectWakeIn)
          begin
            state_d = MODE_READY;
          end
        end
        default:
        begin
          state_d = MODE_POR;
        end
      endcase
    end
  end

  // mode register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      modeState <= MODE_POR;
    end
    else
    begin
      modeState <= state_d;
    end
  end

  // ***********************************************************
  // power and transmitter enables
  // ***********************************************************
  // thermal shutdown overrides the regulator plan of every mode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      powerCtrl <= POWER_RESET;
    end
    else
    begin
      powerCtrl <= modePower(state_d);
      if (pins_q.thermalOverload)
      begin
        powerCtrl.regEnable <= 1'b0;
      end
    end
  end

  // transmitter only in operation, with the line high and no fault
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txEnable <= 1'b0;
    end
    else
    begin
      txEnable <= modePower(state_d).txAllowed &
                  pins_q.faultTxEnableLine &
                  ~internalFault;
    end
  end

  // ***********************************************************
  // pin drivers
  // ***********************************************************
  // open-drain outputs only ever pull low
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busLineOut <= 1'b0;
      busLineOeN <= 1'b1;
      faultTxEnableLineOut <= 1'b0;
      faultTxEnableLineOeN <= 1'b1;
      contentionFault <= 1'b0;
      rxData <= 1'b1;
    end
    else
    begin
      busLineOut <= 1'b0;
      busLineOeN <= ~(txEnable & ~pins_q.txData);
      faultTxEnableLineOut <= 1'b0;
      // pull the line low while the transmitter is blocked inside,
      // but not in modes whose regulator plan is off (reset, power-down)
      faultTxEnableLineOeN <= ~(internalFault &
                                modePower(modeState).regEnable);
      contentionFault <= contention_q;
      rxData <= pins_q.busLine;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  sequence wakeSeen_s;
    modeState == MODE_PDOWN && busWake_q && !pins_q.supplyBelowOff;
  endsequence
  sequence csDrop_s;
    modeState == MODE_OPER && csFall && !pins_q.supplyBelowOff;
  endsequence
  pdownEntry_a: assert property (
    $changed(modeState) && modeState == MODE_PDOWN |->
    $past(modeState) inside {MODE_OPER, MODE_TXOFF})
    else $error("power-down entered from a wrong mode");
  txOnlyOper_a: assert property (txEnable |-> modeState == MODE_OPER)
    else $error("transmitter enabled outside operation");
  txSafe_a: assert property (
    txEnable |-> $past(pins_q.regOk) && !$past(pins_q.thermalOverload))
    else $error("transmitter enabled while regulator unsafe");
  busDrive_a: assert property (
    !busLineOeN |-> $past(txEnable) && !$past(pins_q.txData))
    else $error("bus driven without enabled low data");
  wakeReady_a: assert property (
    wakeSeen_s |=> modeState == MODE_READY)
    else $error("bus wake did not reach ready");
  csPdown_a: assert property (
    csDrop_s |=> modeState == MODE_PDOWN)
    else $error("chip-select drop did not power down");

endmodule : ltmc_mode_ctrl

// >>> hw/ltmc_pkg.sv
// constants, state encoding and carrier structs for the transceiver
// mode controller; assumes a single 20 MHz clock and a synchronous reset
package ltmc_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 50; // 20 MHz core clock
  localparam int WAKE_MIN_NS = 10000; // least bus-low time for a wake
  localparam int DEBOUNCE_NS = 25000; // compare blanking after tx falls
  localparam int CNT_W = 9; // wide enough for both counts
  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] WAKE_CYC =
    CNT_W'((WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DEBOUNCE_CYC =
    CNT_W'((DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

  // ***********************************************************
  // modes
  // ***********************************************************
  typedef enum logic [2:0] {
    MODE_POR,
    MODE_READY,
    MODE_OPER,
    MODE_PDOWN,
    MODE_TXOFF
  } ltmc_state_t;

  // ***********************************************************
  // carriers
  // ***********************************************************
  // every input from outside the clock domain, synchronised as one
  typedef struct packed {
    logic chipSelectWakeIn; // chip-select / local wake level
    logic faultTxEnableLine; // sensed level of the open-drain line
    logic busLine; // sensed bus level, high is recessive
    logic txData; // host transmit data
    logic supplyAboveOn; // supply above the on threshold
    logic supplyBelowOff; // supply below the off threshold
    logic regOk; // regulator output stable
    logic thermalOverload; // any thermal cause
    logic busBelowWake; // bus under the wake threshold
  } ltmc_pins_t;

  // idle levels: lines recessive, flags clear
  localparam ltmc_pins_t PINS_RESET = 9'h0E0;

  // power and enable outputs of one mode
  typedef struct packed {
    logic regEnable; // regulator on
    logic rxEnable; // receiver / activity detect on
    logic txAllowed; // mode lets the transmitter run
    logic digitalReset; // digital section held in reset
  } ltmc_power_t;

  localparam ltmc_power_t POWER_RESET = 4'h1;

endpackage : ltmc_pkg

// >>> bench/ltmc_host_model.sv
// host-side model: control pins and the two open-drain lines
// assumes the bench drives the host intents at the falling edge
`timescale 1ns/10ps

module ltmc_host_model
(
  // host intents
  input wire logic hostCs,
  input wire logic hostTxd,
  input wire logic hostFaultLow,
  // far bus conditions
  input wire logic remoteDom,
  input wire logic busStuck,
  // device side
  input wire logic busLineOut,
  input wire logic busLineOeN,
  input wire logic faultOut,
  input wire logic faultOeN,
  input wire logic regOn,
  input wire logic rxData,
  // resolved levels
  output logic csLevel,
  output logic txLevel,
  output logic busLevel,
  output logic faultLevel,
  output logic contentionSeen
);
  // ***********************************************************
  // line resolution
  // ***********************************************************
  // chip select is a plain host output
  assign csLevel = hostCs;
  // tx held low while the regulator is off, no back-powering
  assign txLevel = hostTxd & regOn;
  // pull-up wins unless someone pulls; stuck means shorted high
  assign busLevel = busStuck | ~((~busLineOeN & ~busLineOut) | remoteDom);
  // fault line: pull-up, device or host may pull it low
  assign faultLevel = ~((~faultOeN & ~faultOut) | hostFaultLow);
  // host's own view of contention: sending high, reading low
  assign contentionSeen = hostTxd & ~rxData;
endmodule : ltmc_host_model

// >>> bench/tb.sv
// self-checking bench for the transceiver mode controller
// assumes the host model resolves all lines; flags driven directly
`timescale 1ns/10ps

module tb import ltmc_pkg::*;;
  // ***********************************************************
  // signals
  // ***********************************************************
  logic clk, sys_rst, hostCs, hostTxd, hostFaultLow, remoteDom, busStuck;
  logic supOn, supOff, regOk, thermal;
  logic busLineOut, busLineOeN, faultOut, faultOeN, rxData, txEnable;
  logic contentionFault, csLevel, txLevel, busLevel, faultLevel;
  ltmc_pins_t pinsAsync;
  ltmc_state_t modeState;
  ltmc_power_t powerCtrl;
  int num_errors = 0;
  int tests_run = 0;

  // free-running 50 ns clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // pins gathered as the design expects them
  always_comb pinsAsync = '{csLevel, faultLevel, busLevel, txLevel,
    supOn, supOff, regOk, thermal, ~busLevel};

  ltmc_mode_ctrl dut_u (.clk(clk), .sys_rst(sys_rst),
    .pinsAsync(pinsAsync), .busLineOut(busLineOut),
    .busLineOeN(busLineOeN), .faultTxEnableLineOut(faultOut),
    .faultTxEnableLineOeN(faultOeN), .rxData(rxData),
    .modeState(modeState), .powerCtrl(powerCtrl), .txEnable(txEnable),
    .contentionFault(contentionFault));

  ltmc_host_model host_u (.hostCs(hostCs), .hostTxd(hostTxd),
    .hostFaultLow(hostFaultLow), .remoteDom(remoteDom),
    .busStuck(busStuck), .busLineOut(busLineOut),
    .busLineOeN(busLineOeN), .faultOut(faultOut), .faultOeN(faultOeN),
    .regOn(powerCtrl.regEnable), .rxData(rxData), .csLevel(csLevel),
    .txLevel(txLevel), .busLevel(busLevel), .faultLevel(faultLevel),
    .contentionSeen());

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // compare with case equality so unknowns never match
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // synchroniser latency is unknown, so poll with a bound
  task automatic waitMode(input ltmc_state_t m);
    int i;
    i = 0;
    while (modeState !== m && i < 4000)
    begin
      @(negedge clk);
      i++;
    end
    check("mode", modeState, m);
    if (i >= 4000)
      test_done();
    // let a brief pass through another mode settle first
    cyc(8);
  endtask : waitMode

  // ***********************************************************
  // sequence
  // ***********************************************************
  initial
  begin
    sys_rst = 1'b1;
    {hostCs, hostFaultLow, remoteDom, busStuck} = 4'h0;
    {supOn, supOff, regOk, thermal} = 4'h0;
    hostTxd = 1'b1;
    cyc(6);
    sys_rst = 1'b0;
    cyc(4);
    // supply low: held in reset, all off
    waitMode(MODE_POR);
    check("power", powerCtrl, 8'h01);
    supOn = 1'b1;
    waitMode(MODE_READY);
    check("power", powerCtrl, 8'h0C);
    check("rx", rxData, 8'h01);
    // chip select alone is not enough without regulator ok
    hostCs = 1'b1;
    cyc(20);
    check("mode", modeState, MODE_READY);
    regOk = 1'b1;
    waitMode(MODE_OPER);
    check("power", powerCtrl, 8'h0E);
    check("txen", txEnable, 8'h01);
    hostTxd = 1'b0;
    cyc(10);
    check("rx", rxData, 8'h00);
    hostTxd = 1'b1;
    cyc(10);
    check("rx", rxData, 8'h01);
    remoteDom = 1'b1;
    cyc(10);
    check("rx", rxData, 8'h00);
    remoteDom = 1'b0;
    regOk = 1'b0;
    cyc(10);
    check("txen", txEnable, 8'h00);
    regOk = 1'b1;
    cyc(10);
    hostFaultLow = 1'b1;
    waitMode(MODE_TXOFF);
    check("txen", txEnable, 8'h00);
    check("power", powerCtrl, 8'h0C);
    hostFaultLow = 1'b0;
    waitMode(MODE_OPER);
    // thermal trip: transmitter and regulator both off
    thermal = 1'b1;
    cyc(10);
    check("txen", txEnable, 8'h00);
    check("reg", powerCtrl.regEnable, 8'h00);
    check("fault", faultLevel, 8'h00);
    thermal = 1'b0;
    waitMode(MODE_OPER);
    // bus shorted high while sending low: flagged only after blanking
    busStuck = 1'b1;
    hostTxd = 1'b0;
    cyc(int'(DEBOUNCE_CYC) / 2);
    check("cont", contentionFault, 8'h00);
    cyc(int'(DEBOUNCE_CYC) / 2 + 20);
    check("cont", contentionFault, 8'h01);
    check("fault", faultLevel, 8'h00);
    hostTxd = 1'b1;
    busStuck = 1'b0;
    waitMode(MODE_OPER);
    hostFaultLow = 1'b1;
    waitMode(MODE_TXOFF);
    hostCs = 1'b0;
    waitMode(MODE_PDOWN);
    hostFaultLow = 1'b0;
    check("power", powerCtrl, 8'h04);
    // a bus pulse shorter than the wake time is ignored
    remoteDom = 1'b1;
    cyc(int'(WAKE_CYC) / 2);
    remoteDom = 1'b0;
    cyc(20);
    check("mode", modeState, MODE_PDOWN);
    remoteDom = 1'b1;
    cyc(int'(WAKE_CYC) + 20);
    remoteDom = 1'b0;
    waitMode(MODE_READY);
    check("reg", powerCtrl.regEnable, 8'h01);
    hostCs = 1'b1;
    waitMode(MODE_OPER);
    hostCs = 1'b0;
    waitMode(MODE_PDOWN);
    check("txen", txEnable, 8'h00);
    hostCs = 1'b1;
    waitMode(MODE_OPER);
    // brown-out, then ready must not fall into power-down
    regOk = 1'b0;
    hostCs = 1'b0;
    {supOn, supOff} = 2'h1;
    waitMode(MODE_POR);
    {supOn, supOff} = 2'h2;
    waitMode(MODE_READY);
    hostCs = 1'b1;
    cyc(10);
    hostCs = 1'b0;
    cyc(20);
    check("mode", modeState, MODE_READY);
    // power-on with chip select high goes straight on
    {supOn, supOff} = 2'h1;
    waitMode(MODE_POR);
    regOk = 1'b1;
    hostCs = 1'b1;
    {supOn, supOff} = 2'h2;
    waitMode(MODE_OPER);
    test_done();
  end
endmodule : tb
